// >>> src/fmt_pkg.sv
// Register map, field layout and codes of the sample output formatter
package fmt_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int SAMPLE_W = 16;
    localparam int NUM_CONV = 16;
    localparam int CONV_W   = 4;
    localparam int IDX_W    = 10;
    localparam int CTRL_N   = 3;

    typedef logic [SAMPLE_W-1:0] sample_t;
    typedef logic [NUM_CONV-1:0] conv_vec_t;
    typedef logic [IDX_W-1:0]    reg_idx_t;
    typedef logic [3:0]          src_sel_t;
    typedef logic [1:0]          code_sel_t;

    // ------------------------------------------------------------
    // Register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam reg_idx_t IDX_SAMPLE_CODING = 10'h18A;
    localparam reg_idx_t IDX_ROUTING_LOW   = 10'h18B;
    localparam reg_idx_t IDX_ROUTING_HIGH  = 10'h18C;
    localparam reg_idx_t IDX_OVR_CLEAR_0   = 10'h18D;
    localparam reg_idx_t IDX_OVR_CLEAR_1   = 10'h18E;
    localparam reg_idx_t IDX_OVR_MASK_0    = 10'h1A0;
    localparam reg_idx_t IDX_OVR_MASK_1    = 10'h1A1;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_INVERT    = 2;
    localparam int POS_CODE_LO   = 0;
    localparam int POS_FLAG0_LO  = 0;
    localparam int POS_FLAG1_LO  = 4;
    localparam int POS_FLAG2_LO  = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RST_SAMPLE_CODING = 3'h0;
    localparam logic [7:0] RST_ROUTING_LOW   = 8'h00;
    localparam logic [3:0] RST_ROUTING_HIGH  = 4'h0;
    localparam conv_vec_t  RST_OVR_MASK      = 16'h0000;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam code_sel_t CODE_TWOS   = 2'h0;
    localparam code_sel_t CODE_OFFSET = 2'h1;
    localparam code_sel_t CODE_GRAY   = 2'h2;
    localparam src_sel_t  SRC_OVR     = 4'h0;
    localparam src_sel_t  SRC_SYSREF  = 4'h1;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// >>> src/sample_coder.sv
// Inversion and output coding of one converter sample
`timescale 1ns/1ps
module sample_coder
    import fmt_pkg::*;
(
    // Raw sample and settings
    input  wire fmt_pkg::sample_t   raw,
    input  wire logic               invert,
    input  wire fmt_pkg::code_sel_t code,
    // Coded sample
    output      fmt_pkg::sample_t   coded
);
    sample_t inv_s;
    sample_t offs_s;

    always_comb begin
        // Inversion comes before re-coding
        inv_s  = invert ? ~raw : raw;
        offs_s = {~inv_s[SAMPLE_W-1], inv_s[SAMPLE_W-2:0]};
        unique case (code)
            CODE_OFFSET: coded = offs_s;
            CODE_GRAY:   coded = offs_s ^ (offs_s >> 1);
            default:     coded = inv_s;
        endcase
    end
endmodule

// >>> src/adc_output_formatter.sv
// Sample output formatter with AHB-Lite register slave and overrange flags
//
// Operation
// RULE_01: Invert enable set inverts every sample; clear passes samples unchanged.
// RULE_02: Code select 00 two's complement, 01 offset binary, 10 Gray code.
// RULE_03: Reset leaves inversion off and two's complement coding selected.
// RULE_04: Control bit 1 source from upper selector: 00 overrange, 01 SYSREF.
// RULE_05: Control bit 0 source from lower selector: 00 overrange, 01 SYSREF.
// RULE_06: Control bit 2 has its own writable selector in a separate register.
// RULE_07: Overrange sticky flag holds until software writes one to its clear bit.
// RULE_08: Reserved bits read zero, ignore writes; unlisted codes are unsupported.
`timescale 1ns/1ps
module adc_output_formatter
    import fmt_pkg::*;
(
    // Clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              NRST,
    // AHB-Lite slave
    input  wire logic              HSEL,
    input  wire logic [31:0]       HADDR,
    input  wire logic [1:0]        HTRANS,
    input  wire logic              HWRITE,
    input  wire logic [2:0]        HSIZE,
    input  wire logic [31:0]       HWDATA,
    input  wire logic              HREADY,
    output      logic              HREADYOUT,
    output      logic              HRESP,
    output      logic [31:0]       HRDATA,
    // Converter sample stream
    input  wire fmt_pkg::sample_t  SAMPLE_IN,
    input  wire logic              SAMPLE_VALID,
    input  wire logic [CONV_W-1:0] SAMPLE_CONV,
    input  wire logic              SAMPLE_OVR,
    input  wire logic              SYSREF,
    // Formatted stream to the framer
    output      fmt_pkg::sample_t  FMT_SAMPLE,
    output      logic              FMT_VALID,
    output      logic [CTRL_N-1:0] FMT_CTRL,
    // Interrupt
    output      logic              IRQ
);
    import fmt_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic       wr_pend,      next_wr_pend;
    reg_idx_t   wr_idx,       next_wr_idx;
    logic [2:0] coding_cfg,   next_coding_cfg;
    logic [7:0] route_low,    next_route_low;
    logic [3:0] route_high,   next_route_high;
    conv_vec_t  sticky,       next_sticky;
    conv_vec_t  ovr_mask,     next_ovr_mask;
    conv_vec_t  ovr_set;
    conv_vec_t  ovr_clr;
    logic [31:0] next_hrdata;
    logic        next_irq;
    sample_t     coded;
    src_sel_t    src_sel [CTRL_N];
    logic [CTRL_N-1:0] next_ctrl;
    logic        addr_ok;
    reg_idx_t    addr_idx;
    logic        bus_req;

    // ------------------------------------------------------------
    // AHB-Lite address phase
    // ------------------------------------------------------------
    always_comb begin
        addr_idx     = HADDR[IDX_W+1:2];
        addr_ok      = (HADDR[31:IDX_W+2] == 20'h00000) && (HADDR[1:0] == 2'h0);
        bus_req      = HSEL && HREADY && HTRANS[1];
        next_wr_pend = bus_req && HWRITE && addr_ok;
        next_wr_idx  = addr_idx;
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            wr_pend <= 1'b0;
            wr_idx  <= 10'h000;
        end else begin
            wr_pend <= next_wr_pend;
            wr_idx  <= next_wr_idx;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_comb begin
        next_coding_cfg = coding_cfg;
        next_route_low  = route_low;
        next_route_high = route_high;
        next_ovr_mask   = ovr_mask;
        if (wr_pend) begin
            unique case (wr_idx)
                // RULE_08 reserved bits dropped
                IDX_SAMPLE_CODING: next_coding_cfg = HWDATA[2:0];
                IDX_ROUTING_LOW:   next_route_low  = HWDATA[7:0];
                // RULE_06 own flag2 register
                IDX_ROUTING_HIGH:  next_route_high = HWDATA[3:0];
                IDX_OVR_MASK_0:    next_ovr_mask[7:0]  = HWDATA[7:0];
                IDX_OVR_MASK_1:    next_ovr_mask[15:8] = HWDATA[7:0];
                default: ;
            endcase
        end
    end

    // RULE_03 zero reset defaults
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            coding_cfg <= RST_SAMPLE_CODING;
            route_low  <= RST_ROUTING_LOW;
            route_high <= RST_ROUTING_HIGH;
            ovr_mask   <= RST_OVR_MASK;
        end else begin
            coding_cfg <= next_coding_cfg;
            route_low  <= next_route_low;
            route_high <= next_route_high;
            ovr_mask   <= next_ovr_mask;
        end
    end

    // ------------------------------------------------------------
    // Overrange sticky flags and interrupt
    // ------------------------------------------------------------
    always_comb begin
        ovr_set = '0;
        ovr_clr = '0;
        if (SAMPLE_VALID && SAMPLE_OVR) begin
            ovr_set[SAMPLE_CONV] = 1'b1;
        end
        if (wr_pend && wr_idx == IDX_OVR_CLEAR_0) begin
            ovr_clr[7:0] = HWDATA[7:0];
        end
        if (wr_pend && wr_idx == IDX_OVR_CLEAR_1) begin
            ovr_clr[15:8] = HWDATA[7:0];
        end
        // RULE_07 hold until write-one clear, set wins
        next_sticky = (sticky & ~ovr_clr) | ovr_set;
        next_irq    = |(next_sticky & next_ovr_mask);
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            sticky <= '0;
            IRQ    <= 1'b0;
        end else begin
            sticky <= next_sticky;
            IRQ    <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Read data, taken from next values so a preceding write shows
    // ------------------------------------------------------------
    always_comb begin
        next_hrdata = HRDATA;
        if (bus_req && !HWRITE) begin
            // RULE_08 reserved and unmapped read zero
            next_hrdata = 32'h00000000;
            if (addr_ok) begin
                unique case (addr_idx)
                    IDX_SAMPLE_CODING: next_hrdata[2:0] = next_coding_cfg;
                    IDX_ROUTING_LOW:   next_hrdata[7:0] = next_route_low;
                    IDX_ROUTING_HIGH:  next_hrdata[3:0] = next_route_high;
                    IDX_OVR_CLEAR_0:   next_hrdata[7:0] = next_sticky[7:0];
                    IDX_OVR_CLEAR_1:   next_hrdata[7:0] = next_sticky[15:8];
                    IDX_OVR_MASK_0:    next_hrdata[7:0] = next_ovr_mask[7:0];
                    IDX_OVR_MASK_1:    next_hrdata[7:0] = next_ovr_mask[15:8];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            HRDATA    <= 32'h00000000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HRDATA    <= next_hrdata;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sample path
    // ------------------------------------------------------------
    // RULE_01 invert and RULE_02 coding
    sample_coder u_coder (
        .raw    (SAMPLE_IN),
        .invert (coding_cfg[POS_INVERT]),
        .code   (coding_cfg[POS_CODE_LO +: 2]),
        .coded  (coded)
    );

    assign src_sel[0] = route_low[POS_FLAG0_LO +: 4];
    assign src_sel[1] = route_low[POS_FLAG1_LO +: 4];
    assign src_sel[2] = route_high[POS_FLAG2_LO +: 4];

    // RULE_04 RULE_05 RULE_06 control bit muxes
    for (genvar g = 0; g < CTRL_N; g++) begin : g_ctrl
        always_comb begin
            unique case (src_sel[g])
                SRC_OVR:    next_ctrl[g] = SAMPLE_OVR;
                SRC_SYSREF: next_ctrl[g] = SYSREF;
                default:    next_ctrl[g] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            FMT_SAMPLE <= '0;
            FMT_VALID  <= 1'b0;
            FMT_CTRL   <= '0;
        end else begin
            FMT_SAMPLE <= SAMPLE_VALID ? coded : FMT_SAMPLE;
            FMT_VALID  <= SAMPLE_VALID;
            FMT_CTRL   <= SAMPLE_VALID ? next_ctrl : FMT_CTRL;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    logic first_cyc;
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            first_cyc <= 1'b1;
        end else begin
            first_cyc <= 1'b0;
        end
    end

    invert_twos_a: assert property ( // RULE_01
        SAMPLE_VALID && coding_cfg == 3'h4 |=> FMT_SAMPLE == ~$past(SAMPLE_IN))
        else $error("inverted sample wrong");
    plain_twos_a: assert property ( // RULE_01
        SAMPLE_VALID && coding_cfg == 3'h0 |=> FMT_SAMPLE == $past(SAMPLE_IN))
        else $error("pass-through sample wrong");
    offset_code_a: assert property ( // RULE_02
        SAMPLE_VALID && coding_cfg == 3'h1 |=>
        FMT_SAMPLE == {~$past(SAMPLE_IN[15]), $past(SAMPLE_IN[14:0])})
        else $error("offset binary wrong");
    gray_code_a: assert property ( // RULE_02
        SAMPLE_VALID && coding_cfg == 3'h2 |=>
        FMT_SAMPLE[15] == ~$past(SAMPLE_IN[15]) &&
        FMT_SAMPLE[14:0] == ({~$past(SAMPLE_IN[15]), $past(SAMPLE_IN[14:1])} ^ $past(SAMPLE_IN[14:0])))
        else $error("gray code wrong");
    reset_defaults_a: assert property ( // RULE_03
        first_cyc |-> coding_cfg == 3'h0 && route_low == 8'h00 && route_high == 4'h0)
        else $error("reset defaults wrong");
    flag1_route_a: assert property ( // RULE_04
        SAMPLE_VALID && route_low[7:4] == 4'h1 |=> FMT_CTRL[1] == $past(SYSREF))
        else $error("control bit 1 route wrong");
    flag0_route_a: assert property ( // RULE_05
        SAMPLE_VALID && route_low[3:0] == 4'h0 |=> FMT_CTRL[0] == $past(SAMPLE_OVR))
        else $error("control bit 0 route wrong");
    flag2_route_a: assert property ( // RULE_06
        SAMPLE_VALID && route_high == 4'h1 |=> FMT_CTRL[2] == $past(SYSREF))
        else $error("control bit 2 route wrong");
    sticky_hold_a: assert property ( // RULE_07
        sticky[0] && !(wr_pend && wr_idx == IDX_OVR_CLEAR_0 && HWDATA[0]) |=> sticky[0])
        else $error("sticky flag lost");
    reserved_zero_a: assert property ( // RULE_08
        HREADY && HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE && HADDR == 32'h00000628 |=> HRDATA[31:3] == 29'h0)
        else $error("reserved bits not zero");
    irq_level_a: assert property (
        |(sticky & ovr_mask) |-> IRQ)
        else $error("interrupt missing");
    fmt_valid_a: assert property ( // RULE_01
        SAMPLE_VALID |=> FMT_VALID)
        else $error("formatted sample not issued");
    idle_valid_a: assert property ( // RULE_01
        !SAMPLE_VALID |=> !FMT_VALID)
        else $error("formatted valid without sample");
    flag1_ovr_a: assert property ( // RULE_04
        SAMPLE_VALID && route_low[7:4] == 4'h0 |=> FMT_CTRL[1] == $past(SAMPLE_OVR))
        else $error("control bit 1 overrange route wrong");
    flag0_sysref_a: assert property ( // RULE_05
        SAMPLE_VALID && route_low[3:0] == 4'h1 |=> FMT_CTRL[0] == $past(SYSREF))
        else $error("control bit 0 reference route wrong");
    flag2_ovr_a: assert property ( // RULE_06
        SAMPLE_VALID && route_high == 4'h0 |=> FMT_CTRL[2] == $past(SAMPLE_OVR))
        else $error("control bit 2 overrange route wrong");
    sticky_set_a: assert property ( // RULE_07
        SAMPLE_VALID && SAMPLE_OVR && SAMPLE_CONV == 4'h0 |=> sticky[0])
        else $error("overrange not recorded");
    sticky_clear_a: assert property ( // RULE_07
        wr_pend && wr_idx == IDX_OVR_CLEAR_0 && HWDATA[0] &&
        !(SAMPLE_VALID && SAMPLE_OVR && SAMPLE_CONV == 4'h0) |=> !sticky[0])
        else $error("sticky flag not cleared");
    coding_write_a: assert property ( // RULE_08
        wr_pend && wr_idx == IDX_SAMPLE_CODING |=> coding_cfg == $past(HWDATA[2:0]))
        else $error("coding register write wrong");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    ovr_event_c:    cover property (SAMPLE_VALID && SAMPLE_OVR ##1 IRQ);
    gray_out_c:     cover property (SAMPLE_VALID && coding_cfg[1:0] == CODE_GRAY);
    sticky_clr_c:   cover property (sticky[0] ##1 !sticky[0]);
    sysref_route_c: cover property (SAMPLE_VALID && route_low == 8'h11 && SYSREF);
    invert_gray_c:  cover property (SAMPLE_VALID && coding_cfg == 3'h6);
endmodule

// >>> test/framer_model.sv
// Behavioural transmit framer that takes the formatted stream
`timescale 1ns/1ps
module framer_model
    import fmt_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Formatted stream
    input  wire fmt_pkg::sample_t  sample,
    input  wire logic              valid,
    input  wire logic [CTRL_N-1:0] ctrl,
    // Last word taken
    output      fmt_pkg::sample_t  last_sample,
    output      logic [CTRL_N-1:0] last_ctrl,
    output      int                count
);
    // Takes one word in every valid cycle and never stalls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_sample <= '0;
            last_ctrl   <= '0;
            count       <= 0;
        end else if (valid) begin
            last_sample <= sample;
            last_ctrl   <= ctrl;
            count       <= count + 1;
        end
    end
endmodule

// >>> test/adc_sample_output_formatter_tb_top.sv
// Self-checking testbench of the sample output formatter
`timescale 1ns/1ps
module adc_sample_output_formatter_tb_top;
    import fmt_pkg::*;

    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [3:0]  conv;
        logic        ovr;
        logic        sys;
        logic [15:0] smp;
        logic [2:0]  ctl;
    } row_t;

    logic              REF_CLK = 1'h0;
    logic              NRST = 1'h0;
    logic              HSEL = 1'h0;
    logic              HWRITE = 1'h0;
    logic [1:0]        HTRANS = 2'h0;
    logic [31:0]       HADDR = 32'h0;
    logic [31:0]       HWDATA = 32'h0;
    logic              HREADY;
    logic              HREADYOUT;
    logic              HRESP;
    logic [31:0]       HRDATA;
    sample_t           SAMPLE_IN = 16'h0;
    logic              SAMPLE_VALID = 1'h0;
    logic [CONV_W-1:0] SAMPLE_CONV = 4'h0;
    logic              SAMPLE_OVR = 1'h0;
    logic              SYSREF = 1'h0;
    sample_t           FMT_SAMPLE;
    logic              FMT_VALID;
    logic [CTRL_N-1:0] FMT_CTRL;
    logic              IRQ;
    sample_t           last_sample;
    logic [CTRL_N-1:0] last_ctrl;
    int                count;
    int                n_errors = 0;
    int                checks = 0;

    // Raw sample is 16'h1234 in every row
    row_t rows [6] = '{
        '{8'h00, 8'h00, 8'h00, 4'h0, 1'h1, 1'h0, 16'h1234, 3'h7},
        '{8'h01, 8'h10, 8'h01, 4'h1, 1'h1, 1'h0, 16'h9234, 3'h1},
        '{8'h02, 8'h01, 8'h00, 4'h2, 1'h1, 1'h0, 16'hDB2E, 3'h6},
        '{8'h04, 8'h11, 8'h01, 4'h3, 1'h0, 1'h1, 16'hEDCB, 3'h7},
        '{8'h05, 8'h11, 8'h01, 4'h4, 1'h1, 1'h0, 16'h6DCB, 3'h0},
        '{8'h06, 8'h00, 8'h01, 4'h5, 1'h0, 1'h1, 16'h5B2E, 3'h4}};

    assign HREADY = HREADYOUT;

    adc_output_formatter uut (.REF_CLK(REF_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .HRDATA(HRDATA), .SAMPLE_IN(SAMPLE_IN), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_CONV(SAMPLE_CONV),
        .SAMPLE_OVR(SAMPLE_OVR), .SYSREF(SYSREF), .FMT_SAMPLE(FMT_SAMPLE), .FMT_VALID(FMT_VALID),
        .FMT_CTRL(FMT_CTRL), .IRQ(IRQ));

    framer_model framer (.clk(REF_CLK), .rst_n(NRST), .sample(FMT_SAMPLE), .valid(FMT_VALID), .ctrl(FMT_CTRL),
        .last_sample(last_sample), .last_ctrl(last_ctrl), .count(count));

    initial begin
        forever #2 REF_CLK = ~REF_CLK;
    end

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Entered just after a rising edge; holds each phase until ready is seen
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        HSEL   <= 1'h1;
        HTRANS <= HTRANS_NONSEQ;
        HADDR  <= a;
        HWRITE <= w;
        do @(posedge REF_CLK); while (HREADY !== 1'h1);
        HSEL   <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge REF_CLK); while (HREADY !== 1'h1);
        r = HRDATA;
        chk("hresp", 32'h0, HRESP);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'h1, a, d, r);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        bus(1'h0, a, 32'h0, r);
        chk(what, exp, r);
    endtask

    task automatic send(input logic [3:0] conv, input logic ovr, input logic sys, input logic [15:0] smp,
                        input logic [2:0] ctl);
        int n0;
        n0 = count;
        SAMPLE_IN    <= 16'h1234;
        SAMPLE_CONV  <= conv;
        SAMPLE_OVR   <= ovr;
        SYSREF       <= sys;
        SAMPLE_VALID <= 1'h1;
        @(posedge REF_CLK);
        SAMPLE_VALID <= 1'h0;
        @(negedge REF_CLK);
        chk("fmt_valid", 32'h1, FMT_VALID);
        chk("fmt_sample", smp, FMT_SAMPLE);
        chk("fmt_ctrl", ctl, FMT_CTRL);
        @(negedge REF_CLK);
        chk("fmt_valid_drop", 32'h0, FMT_VALID);
        chk("framer_word", {ctl, smp}, {last_ctrl, last_sample});
        chk("framer_count", n0 + 1, count);
        @(posedge REF_CLK);
    endtask

    task automatic irq_chk(input logic e);
        repeat (2) @(posedge REF_CLK);
        @(negedge REF_CLK);
        chk("irq", e, IRQ);
        @(posedge REF_CLK);
    endtask

    task automatic reset_chk();
        rd(32'h628, 32'h0, "coding_reset");
        rd(32'h62C, 32'h0, "routing_low_reset");
        rd(32'h630, 32'h0, "routing_high_reset");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge REF_CLK);
        NRST <= 1'h1;
        @(posedge REF_CLK);
        reset_chk();
        foreach (rows[i]) begin
            wr(32'h628, rows[i].cfg);
            wr(32'h62C, rows[i].lo);
            wr(32'h630, rows[i].hi);
            rd(32'h628, rows[i].cfg, "coding");
            rd(32'h62C, rows[i].lo, "routing_low");
            rd(32'h630, rows[i].hi, "routing_high");
            send(rows[i].conv, rows[i].ovr, rows[i].sys, rows[i].smp, rows[i].ctl);
        end
        wr(32'h628, 32'hFF);
        rd(32'h628, 32'h07, "coding_reserved");
        wr(32'h630, 32'hFF);
        rd(32'h630, 32'h0F, "routing_high_reserved");
        wr(32'h700, 32'hFF);
        rd(32'h700, 32'h0, "unmapped");
        wr(32'h628, 32'h0);
        wr(32'h630, 32'h0);
        wr(32'h634, 32'hFF);
        wr(32'h638, 32'hFF);
        rd(32'h634, 32'h0, "sticky_cleared");
        wr(32'h680, 32'h01);
        send(4'h0, 1'h1, 1'h0, 16'h1234, 3'h7);
        irq_chk(1'h1);
        send(4'h0, 1'h0, 1'h0, 16'h1234, 3'h0);
        rd(32'h634, 32'h01, "sticky_held");
        irq_chk(1'h1);
        wr(32'h634, 32'h01);
        rd(32'h634, 32'h0, "sticky_write_clear");
        irq_chk(1'h0);
        send(4'h9, 1'h1, 1'h0, 16'h1234, 3'h7);
        rd(32'h638, 32'h02, "sticky_high");
        irq_chk(1'h0);
        wr(32'h684, 32'h02);
        irq_chk(1'h1);
        wr(32'h638, 32'h02);
        irq_chk(1'h0);
        wr(32'h628, 32'h06);
        wr(32'h680, 32'h01);
        rd(32'h628, 32'h06, "coding_before_reset");
        send(4'h0, 1'h1, 1'h0, 16'h5B2E, 3'h7);
        irq_chk(1'h1);
        NRST <= 1'h0;
        repeat (3) @(posedge REF_CLK);
        NRST <= 1'h1;
        @(posedge REF_CLK);
        chk("irq_reset", 32'h0, IRQ);
        chk("fmt_sample_reset", 32'h0, FMT_SAMPLE);
        chk("fmt_ctrl_reset", 32'h0, FMT_CTRL);
        reset_chk();
        rd(32'h634, 32'h0, "sticky_reset");
        rd(32'h680, 32'h0, "mask_reset");
        results();
    end

    // About 190 cycles are needed; 10000 cycles cut a hang
    initial begin
        #40000;
        n_errors++;
        results();
    end
endmodule
